// ---- hdl/gpio_port_defs.svh ----
// register offsets, widths and reset values for the gpio port
`ifndef GPIO_PORT_DEFS_SVH
`define GPIO_PORT_DEFS_SVH
`define PIN_COUNT          12
`define ADDR_W             16
`define DATA_FULL_OFS      16'h3FFC
`define WINDOW_TOP_BIT     13
`define CFG_REGION_BIT     15
`define DIR_OFS            16'h8000
`define SENSE_OFS          16'h8004
`define BOTH_EDGE_OFS      16'h8008
`define EVENT_OFS          16'h800C
`define MASK_OFS           16'h8010
`define RAW_OFS            16'h8014
`define MASKED_OFS         16'h8018
`define CLEAR_OFS          16'h801C
`define CFG_RESET          12'h000
`define RDATA_RESET        32'h0000_0000
`define PORT_SEL_LSB       16
`define PORT_SEL_W         2
`endif

// ---- hdl/gpio_port_pkg.sv ----
// types shared by the gpio port
package gpio_port_pkg;
  typedef struct packed {
    logic [11:0] dir;
    logic [11:0] sense;
    logic [11:0] both;
    logic [11:0] event_pol;
    logic [11:0] mask;
    logic [11:0] latch;
    logic [11:0] out_val;
    logic [11:0] sync1;
    logic [11:0] sync2;
    logic [11:0] prev;
    logic [31:0] rdata;
    logic [11:0] pin_out;
    logic [11:0] pin_oe;
    logic [11:0] masked;
    logic        irq;
  } gpio_state_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [1:0]  wsize;
    logic        wr;
    logic        rd;
  } bus_req_t;
endpackage : gpio_port_pkg

// ---- hdl/gpio_port.sv ----
// 12-pin gpio port with per-pin edge or level interrupts
`include "gpio_port_defs.svh"

//
// Contract
// - each pin's direction bit selects input or output
// - after reset all pins input; config registers reset to zero
// - every pin can request an interrupt, edge or level sensitive
// - edge mode fires on falling, rising or both edges
// - level mode fires on high or low level
// - data accesses masked by address bits 13:2, one per pin
// - registers hold 12 bits; word or half-word; upper bits reserved; half-word writes here reach only pins 7:0
// - one port per 64 KB region, identical layout
// - offsets up to 3FF8 are the masked window; 3FFC is full data
// - data reads return the sampled pin level in every mode
// - gpio output pins drive the stored data value
// - writes to an input pin's data bit do not change the pin
// - pins given to another function ignore data writes, still read
// - switching to output first drives the level held just before
// - direction, sense, both-edge, event, mask at 8000 to 8010
// - raw status at 8014, read only, resets to zero
// - masked status at 8018 reports raw and mask
// - write-only clear register at 801C
// - sense zero is edge, one is level
// - both-edge one fires on either edge; zero defers to event bits
// - event zero is falling or low, one rising or high
// - mask one lets the pin raise its interrupt and the combined line
module gpio_port
  import gpio_port_pkg::*;
#(
  parameter logic [1:0] PORT_INDEX = 2'h0
) (
  input  wire logic              clock,
  input  wire logic              nrst,
  input  wire bus_req_t          bus_req,
  output logic      [31:0]       bus_rdata,
  input  wire logic [11:0]       port_pin_in,
  output logic      [11:0]       port_pin_out,
  output logic      [11:0]       port_pin_oe,
  input  wire logic [11:0]       alt_func_sel,
  input  wire logic [11:0]       alt_func_out,
  input  wire logic [11:0]       alt_func_oe,
  output logic      [11:0]       pin_irq,
  output logic                   port_irq
);

  gpio_state_t s_q;
  gpio_state_t s_d;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic                  port_hit;
  logic [`ADDR_W-1:0]    ofs;
  logic                  data_win;
  logic [11:0]           amask;
  logic [11:0]           wlane;
  logic [11:0]           wbits;
  logic [11:0]           level;
  logic [11:0]           rise;
  logic [11:0]           fall;
  logic [11:0]           edge_hit;
  logic [11:0]           lvl_hit;
  logic [11:0]           raw;
  logic [11:0]           rsel;
  logic                  wr_ok;

  always_comb begin
    port_hit = (bus_req.addr[`PORT_SEL_LSB +: `PORT_SEL_W] == PORT_INDEX);
    ofs      = bus_req.addr[`ADDR_W-1:0];
    data_win = !ofs[`CFG_REGION_BIT] && !ofs[`WINDOW_TOP_BIT+1];
    amask    = ofs[`WINDOW_TOP_BIT:2];
    // half-word writes touch only the low 8 pins of the low half-word
    wlane    = (bus_req.wsize == 2'h1) ? 12'h0FF : 12'hFFF;
    wbits    = bus_req.wdata[11:0];
    wr_ok    = bus_req.wr && port_hit;
  end

  // ----------------------------------------------------------------
  // interrupt detection
  // ----------------------------------------------------------------
  always_comb begin
    level    = s_q.sync2;
    rise     = level & ~s_q.prev;
    fall     = ~level & s_q.prev;
    edge_hit = (s_q.both & (rise | fall)) |
               (~s_q.both & s_q.event_pol & rise) |
               (~s_q.both & ~s_q.event_pol & fall);
    lvl_hit  = (s_q.event_pol & level) | (~s_q.event_pol & ~level);
    raw      = (s_q.sense & lvl_hit) | (~s_q.sense & s_q.latch);
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d       = s_q;
    s_d.sync1 = port_pin_in;
    s_d.sync2 = s_q.sync1;
    s_d.prev  = s_q.sync2;
    s_d.rdata = `RDATA_RESET;
    rsel      = 12'h000;

    // edge latch: a new edge wins over a clear in the same cycle
    if (wr_ok && ofs == `CLEAR_OFS) begin
      s_d.latch = s_q.latch & ~(wbits & wlane);
    end
    s_d.latch = s_d.latch | (~s_q.sense & edge_hit);

    // pin level follows the data register only for gpio outputs
    for (int i = 0; i < `PIN_COUNT; i++) begin
      // tracking the pin while not a gpio output makes the switch glitch-free
      if (!s_q.dir[i] || alt_func_sel[i]) begin
        s_d.out_val[i] = s_q.sync2[i];
      end
    end

    if (wr_ok) begin
      if (data_win) begin
        for (int i = 0; i < `PIN_COUNT; i++) begin
          if (amask[i] && wlane[i] && s_q.dir[i] && !alt_func_sel[i]) begin
            s_d.out_val[i] = wbits[i];
          end
        end
      end else begin
        case (ofs)
          `DIR_OFS:       s_d.dir       = (s_q.dir & ~wlane) | (wbits & wlane);
          `SENSE_OFS:     s_d.sense     = (s_q.sense & ~wlane) | (wbits & wlane);
          `BOTH_EDGE_OFS: s_d.both      = (s_q.both & ~wlane) | (wbits & wlane);
          `EVENT_OFS:     s_d.event_pol = (s_q.event_pol & ~wlane) | (wbits & wlane);
          `MASK_OFS:      s_d.mask      = (s_q.mask & ~wlane) | (wbits & wlane);
          default:        s_d.dir       = s_q.dir;
        endcase
      end
    end

    if (bus_req.rd && port_hit) begin
      if (data_win) begin
        rsel = s_q.sync2 & amask;
      end else begin
        case (ofs)
          `DIR_OFS:       rsel = s_q.dir;
          `SENSE_OFS:     rsel = s_q.sense;
          `BOTH_EDGE_OFS: rsel = s_q.both;
          `EVENT_OFS:     rsel = s_q.event_pol;
          `MASK_OFS:      rsel = s_q.mask;
          `RAW_OFS:       rsel = raw;
          `MASKED_OFS:    rsel = raw & s_q.mask;
          default:        rsel = 12'h000;
        endcase
      end
      s_d.rdata = {20'h00000, rsel};
    end

    // pad drive: alternate function owns the pad when selected
    for (int i = 0; i < `PIN_COUNT; i++) begin
      s_d.pin_oe[i]  = alt_func_sel[i] ? alt_func_oe[i] : s_d.dir[i];
      s_d.pin_out[i] = alt_func_sel[i] ? alt_func_out[i] : s_d.out_val[i];
    end

    s_d.masked = raw & s_q.mask;
    s_d.irq    = |(raw & s_q.mask);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus_rdata    = s_q.rdata;
  assign port_pin_out = s_q.pin_out;
  assign port_pin_oe  = s_q.pin_oe;
  assign pin_irq      = s_q.masked;
  assign port_irq     = s_q.irq;

endmodule : gpio_port

// ---- verif/gpio_pad_model.sv ----
// pad model: resolves each pin from core drive, external drive and pull-up
module gpio_pad_model (
  input  wire logic [11:0] drv_out,
  input  wire logic [11:0] drv_oe,
  input  wire logic [11:0] ext_val,
  input  wire logic [11:0] ext_en,
  output logic      [11:0] level
);
  timeunit 1ns;
  timeprecision 1ps;
  // undriven pads float up to the pull-up level
  assign level = (drv_oe & drv_out) | (~drv_oe & ((ext_en & ext_val) | ~ext_en));
endmodule : gpio_pad_model

// ---- verif/gpio_port_chk.sv ----
// assertions on the gpio port bus and pin ports
`include "gpio_port_defs.svh"
module gpio_port_chk
  import gpio_port_pkg::*;
#(
  parameter logic [1:0] PORT_INDEX = 2'h0
) (
  input wire logic        clock,
  input wire logic        nrst,
  input wire bus_req_t    bus_req,
  input wire logic [31:0] bus_rdata,
  input wire logic [11:0] port_pin_oe,
  input wire logic [11:0] alt_func_sel,
  input wire logic [11:0] pin_irq,
  input wire logic        port_irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  wire        mine = bus_req.addr[17:16] == PORT_INDEX;
  wire [15:0] ofs  = bus_req.addr[15:0];
  sequence s_wr(o);
    bus_req.wr && mine && ofs == o && bus_req.wsize == 2'h2 && alt_func_sel == 12'h000;
  endsequence
  sequence s_rd;
    bus_req.rd && mine;
  endsequence
  a_rdata_idle: assert property (!bus_req.rd |=> bus_rdata == 32'h0)
    else $error("read data not idle");
  a_upper_zero: assert property (bus_rdata[31:12] == 20'h0)
    else $error("reserved read bits set");
  a_other_port: assert property (bus_req.rd && !mine |=> bus_rdata == 32'h0)
    else $error("other port answered");
  a_rsvd_read: assert property (s_rd ##0 (ofs[15:14] == 2'h1 || ofs >= 16'h8020) |=>
    bus_rdata == 32'h0) else $error("reserved offset read nonzero");
  a_mask_read: assert property (s_rd ##0 ofs[15:14] == 2'h0 |=>
    (bus_rdata[11:0] & ~$past(ofs[13:2])) == 12'h000) else $error("unselected pin read");
  a_port_or: assert property (port_irq == |pin_irq)
    else $error("port irq not or of pins");
  a_dir_oe: assert property (s_wr(`DIR_OFS) |=>
    port_pin_oe == $past(bus_req.wdata[11:0])) else $error("oe not direction");
  a_mask_off: assert property (s_wr(`MASK_OFS) ##0 bus_req.wdata[11:0] == 12'h000 |=>
    ##2 pin_irq == 12'h000) else $error("masked pin irq");
endmodule : gpio_port_chk
bind gpio_port gpio_port_chk #(.PORT_INDEX(PORT_INDEX)) u_chk (.clock, .nrst, .bus_req,
  .bus_rdata, .port_pin_oe, .alt_func_sel, .pin_irq, .port_irq);

// ---- verif/gpio_port_test.sv ----
// self-checking bench for the gpio port
`include "gpio_port_defs.svh"
module gpio_port_test
  import gpio_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] PI = 2'h1;
  logic        clock, nrst, port_irq;
  bus_req_t    bus_req;
  logic [31:0] bus_rdata;
  logic [11:0] lvl, p_out, p_oe, a_sel, a_out, a_oe, irq, e_val, e_en;
  int          n_errors, comparisons, i;
  gpio_port #(.PORT_INDEX(PI)) dut (.clock(clock), .nrst(nrst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .port_pin_in(lvl), .port_pin_out(p_out), .port_pin_oe(p_oe),
    .alt_func_sel(a_sel), .alt_func_out(a_out), .alt_func_oe(a_oe), .pin_irq(irq),
    .port_irq(port_irq));
  gpio_pad_model pads (.drv_out(p_out), .drv_oe(p_oe), .ext_val(e_val), .ext_en(e_en),
    .level(lvl));
  function automatic logic [31:0] pa(logic [15:0] o);
    return {14'h0, PI, o};
  endfunction : pa
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(logic [31:0] a, logic [31:0] d);
    @(posedge clock);
    bus_req <= '{a, d, 2'h2, 1'b1, 1'b0};
    @(posedge clock);
    bus_req.wr <= 1'b0;
  endtask : wr
  // half-word write: only the low eight pins take the data
  task automatic wrh(logic [31:0] a, logic [31:0] d);
    @(posedge clock);
    bus_req <= '{a, d, 2'h1, 1'b1, 1'b0};
    @(posedge clock);
    bus_req.wr <= 1'b0;
  endtask : wrh
  task automatic rd(logic [31:0] a, logic [31:0] e);
    @(posedge clock);
    bus_req <= '{a, 32'h0, 2'h2, 1'b0, 1'b1};
    @(posedge clock);
    bus_req.rd <= 1'b0;
    #1 check("rdata", bus_rdata, e);
  endtask : rd
  task automatic end_of_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    repeat (5000) @(posedge clock);
    n_errors++;
    end_of_test();
  end
  initial begin
    nrst = 1'b0;
    bus_req = '0;
    {a_sel, a_out, a_oe, e_val} = '0;
    e_en = 12'hFFF;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    check("oe", p_oe, 32'h0);
    for (i = 0; i < 7; i++) rd(pa(16'h8000 + 16'(4 * i)), 32'h0);
    for (i = 0; i < 5; i++) begin
      wr(pa(16'h8000 + 16'(4 * i)), 32'hFFFF_F5A5);
      rd(pa(16'h8000 + 16'(4 * i)), 32'h0000_05A5);
      wr(pa(16'h8000 + 16'(4 * i)), 32'h0);
    end
    wrh(pa(`DIR_OFS), 32'hFFF);
    rd(pa(`DIR_OFS), 32'h0FF);
    wr(pa(`DIR_OFS), 32'h0);
    wr({14'h0, PI + 2'h1, `DIR_OFS}, 32'hFFF);
    rd(pa(`DIR_OFS), 32'h0);
    rd(pa(16'h4000), 32'h0);
    // input pins ignore data writes
    e_val <= 12'hABC;
    wr(pa(`DATA_FULL_OFS), 32'h0);
    repeat (4) @(posedge clock);
    rd(pa(`DATA_FULL_OFS), 32'hABC);
    wr(pa(`DIR_OFS), 32'hFFF);
    e_en <= 12'h000;
    #1 check("out", p_out, 32'hABC);
    wr(pa(16'h003C), 32'h0);
    #1 check("out", p_out, 32'hAB0);
    repeat (4) @(posedge clock);
    rd(pa(16'h03C0), 32'h0B0);
    {a_sel, a_oe} <= {12'h001, 12'h001};
    wr(pa(`DATA_FULL_OFS), 32'hFFF);
    repeat (4) @(posedge clock);
    rd(pa(`DATA_FULL_OFS), 32'hFFE);
    a_sel <= 12'h000;
    wr(pa(`DIR_OFS), 32'h0);
    {e_en, e_val} <= {12'hFFF, 12'h000};
    // pin0 fall, pin1 rise, pin2 both, pin3 high, pin4 low
    repeat (4) @(posedge clock);
    wr(pa(`SENSE_OFS), 32'h018);
    wr(pa(`EVENT_OFS), 32'h00A);
    wr(pa(`BOTH_EDGE_OFS), 32'h004);
    wr(pa(`MASK_OFS), 32'h005);
    wr(pa(`CLEAR_OFS), 32'hFFF);
    rd(pa(`RAW_OFS), 32'h010);
    e_val <= 12'h01F;
    repeat (5) @(posedge clock);
    rd(pa(`RAW_OFS), 32'h00E);
    wr(pa(`CLEAR_OFS), 32'h0);
    rd(pa(`RAW_OFS), 32'h00E);
    wr(pa(`CLEAR_OFS), 32'hFFF);
    rd(pa(`RAW_OFS), 32'h008);
    e_val <= 12'h000;
    repeat (5) @(posedge clock);
    rd(pa(`RAW_OFS), 32'h015);
    rd(pa(`MASKED_OFS), 32'h005);
    check("irq", {port_irq, irq}, 32'h1005);
    wr(pa(`MASK_OFS), 32'h0);
    repeat (3) @(posedge clock);
    check("irq", irq, 32'h0);
    end_of_test();
  end
endmodule : gpio_port_test
